// >>> logic/hot_charge_regs.sv
// Contract
// - Discharge threshold bits 15:10, 512 mA steps
// - Bits 9:8 pick discharge deglitch time
// - Bits 6:0 enable alert sources
// - Adapter absent masks input, battery, adapter sources
// - Envelope bit map; bits 5, 2 reset enabled
// - Battery rise, adapter fall one-shot triggers
// - Charge code bits 12:6, low bits ignored
// - Ones in bits 15:13 void the write
// - Charge current zero after reset
// - Zero charge current stops charging
// - Pre-charge clamps current at 384 mA
// - Single cell clamps 384 mA, then 2 A
// - High byte without low byte is ignored
// - Watchdog expiry discards pending low byte
// - Alert lasts at least selected width
`timescale 1ns/100ps
module hot_charge_regs #(
  parameter int DG_1P6MS = hot_charge_pkg::T_1P6MS_CYC,
  parameter int DG_100US = hot_charge_pkg::T_100US_CYC,
  parameter int DG_6MS   = hot_charge_pkg::T_6MS_CYC,
  parameter int DG_12MS  = hot_charge_pkg::T_12MS_CYC,
  parameter int PW_1MS   = hot_charge_pkg::T_1MS_CYC,
  parameter int WDOG_CYC = hot_charge_pkg::WDOG_CYC_DEF
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // Decoded command writes, word or byte
  input  wire logic        WR_STB,
  input  wire logic        WR_WORD,
  input  wire logic [7:0]  WR_CMD,
  input  wire logic [15:0] WR_DATA,
  // Decoded command reads
  input  wire logic        RD_STB,
  input  wire logic        RD_WORD,
  input  wire logic [7:0]  RD_CMD,
  output logic [15:0]      RD_DATA,
  output logic             RD_VALID,
  output logic             INVALID_WR,
  // Alert sources
  input  wire logic [15:0] DISCHARGE_MA,
  input  wire logic        IND_COMP_TRIP,
  input  wire logic        CRIT_INPUT_TRIP,
  input  wire logic        NOM_INPUT_TRIP,
  input  wire logic        SYS_VOLT_TRIP,
  input  wire logic        BATTERY_PRESENT,
  input  wire logic        ADAPTER_GOOD,
  input  wire logic        ADAPTER_PRESENT,
  // Alert pulse shaping
  input  wire logic [1:0]  PULSE_WIDTH_SEL,
  input  wire logic        PULSE_EXTEND,
  input  wire logic        HOST_CLEAR,
  output logic             PROC_HOT_N,
  // Charge state
  input  wire logic        PRE_CHARGE,
  input  wire logic        SINGLE_CELL,
  input  wire logic        BAT_BELOW_LOW,
  input  wire logic        BAT_BELOW_MINIMUM_SYSTEM_VOLTAGE,
  output logic [6:0]       EFF_CHARGE_CODE,
  output logic             CHARGE_ENABLE
);
  import hot_charge_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] sel4(input logic [1:0] s,
      input int a, input int b, input int c, input int d);
    unique case (s)
      2'h0: sel4 = CNT_W'(a);
      2'h1: sel4 = CNT_W'(b);
      2'h2: sel4 = CNT_W'(c);
      2'h3: sel4 = CNT_W'(d);
    endcase
  endfunction

  function automatic logic [6:0] min7(input logic [6:0] a,
      input logic [6:0] b);
    min7 = (a < b) ? a : b;
  endfunction

  logic [6:0]       code_q;
  logic [5:0]       thr_q;
  logic [1:0]       dg_q;
  logic [6:0]       env_q;
  logic             pend_q;
  logic [7:0]       lo_q;
  logic [31:0]      wd_q;
  logic             bp_q;
  logic             ag_q;
  logic             alert_q;
  logic             ext_q;
  logic             hot_q;
  logic [CNT_W-1:0] hold_q;
  logic             dchg_filt;
  logic [6:0]       src;
  logic [6:0]       eff_en;
  logic             alert;
  logic             cc_word;
  logic             cc_lo;
  logic             cc_hi;
  logic             opt_word;
  logic             opt_lo;
  logic             opt_hi;
  logic             word_bad;
  logic             pair_bad;
  logic [15:0]      pair;
  logic             wd_done;
  logic [6:0]       eff_d;

  // ****************************************
  // Write decode
  // ****************************************
  assign cc_word  = WR_STB && WR_WORD && (WR_CMD == CMD_CC_WORD);
  assign opt_word = WR_STB && WR_WORD && (WR_CMD == CMD_OPT_WORD);
  assign cc_lo    = WR_STB && !WR_WORD && (WR_CMD == CMD_CC_LO);
  assign cc_hi    = WR_STB && !WR_WORD && (WR_CMD == CMD_CC_HI);
  assign opt_lo   = WR_STB && !WR_WORD && (WR_CMD == CMD_OPT_LO);
  assign opt_hi   = WR_STB && !WR_WORD && (WR_CMD == CMD_OPT_HI);
  assign pair     = {WR_DATA[7:0], lo_q};
  assign word_bad = |WR_DATA[CC_BAD_MSB:CC_BAD_LSB];
  assign pair_bad = |pair[CC_BAD_MSB:CC_BAD_LSB];
  assign wd_done  = (wd_q >= 32'(WDOG_CYC - 1));

  // ****************************************
  // Charge current register
  // ****************************************
  // Zero at reset
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      code_q <= CC_CODE_RST;
    end else if (cc_word && !word_bad) begin
      code_q <= WR_DATA[CC_CODE_MSB:CC_CODE_LSB];
    end else if (cc_hi && pend_q && !pair_bad) begin
      code_q <= pair[CC_CODE_MSB:CC_CODE_LSB];
    end
  end

  // Low byte is only staged; any other write breaks the pair
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      pend_q <= 1'b0;
      lo_q   <= 8'h00;
    end else if (cc_lo) begin
      pend_q <= 1'b1;
      lo_q   <= WR_DATA[7:0];
    end else if (WR_STB) begin
      pend_q <= 1'b0;
    end else if (pend_q && wd_done) begin
      pend_q <= 1'b0;
    end
  end

  // Watchdog runs only while a low byte waits
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || cc_lo || !pend_q) begin
      wd_q <= '0;
    end else if (!wd_done) begin
      wd_q <= wd_q + 32'h1;
    end
  end

  // Rejected word or pair, reported for one cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      INVALID_WR <= 1'b0;
    end else begin
      INVALID_WR <= (cc_word && word_bad) ||
                    (cc_hi && pend_q && pair_bad);
    end
  end

  // ****************************************
  // Hot profile register
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      thr_q <= THR_RST;
      dg_q  <= DG_RST;
      env_q <= ENV_RST;
    end else if (opt_word) begin
      thr_q <= WR_DATA[OPT_THR_MSB:OPT_THR_LSB];
      dg_q  <= WR_DATA[OPT_DG_MSB:OPT_DG_LSB];
      env_q <= WR_DATA[OPT_ENV_MSB:0];
    end else if (opt_lo) begin
      env_q <= WR_DATA[OPT_ENV_MSB:0];
    end else if (opt_hi) begin
      thr_q <= WR_DATA[7:2];
      dg_q  <= WR_DATA[1:0];
    end
  end

  // ****************************************
  // Alert sources
  // ****************************************
  // Deglitch select
  deglitch_filter u_dchg (
    .CORE_CLK (CORE_CLK),
    .RESET_N  (RESET_N),
    .RAW      (DISCHARGE_MA > {1'b0, thr_q, 9'h000}),
    .LIMIT    (sel4(dg_q, DG_1P6MS, DG_100US, DG_6MS, DG_12MS)),
    .FILT     (dchg_filt)
  );

  // Edge history for the one-shot sources
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      bp_q <= 1'b0;
      ag_q <= 1'b0;
    end else begin
      bp_q <= BATTERY_PRESENT;
      ag_q <= ADAPTER_GOOD;
    end
  end

  assign src[1] = BATTERY_PRESENT && !bp_q;
  assign src[0] = !ADAPTER_GOOD && ag_q;
  assign src[6] = IND_COMP_TRIP;
  assign src[5] = CRIT_INPUT_TRIP;
  assign src[4] = NOM_INPUT_TRIP;
  assign src[3] = dchg_filt;
  assign src[2] = SYS_VOLT_TRIP;
  assign eff_en = env_q & (ADAPTER_PRESENT ? ENV_ALL : ENV_KEEP);
  assign alert  = |(src & eff_en);

  // ****************************************
  // Alert output shaping
  // ****************************************
  // Minimum width hold
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      alert_q <= 1'b0;
      hold_q  <= '0;
    end else begin
      alert_q <= alert;
      if (alert && !alert_q) begin
        hold_q <= sel4(PULSE_WIDTH_SEL, DG_100US, PW_1MS, DG_12MS,
                       DG_6MS) - 1'b1;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
      end
    end
  end

  // Extension latch; a new trip wins over a host clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ext_q <= 1'b0;
    end else if (alert && PULSE_EXTEND) begin
      ext_q <= 1'b1;
    end else if (HOST_CLEAR || !PULSE_EXTEND) begin
      ext_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      hot_q <= 1'b0;
    end else begin
      hot_q <= alert || (hold_q != '0) || ext_q;
    end
  end
  assign PROC_HOT_N = !hot_q;

  // ****************************************
  // Effective charge current
  // ****************************************
  always_comb begin
    eff_d = code_q;
    if (PRE_CHARGE || (SINGLE_CELL && BAT_BELOW_LOW)) begin
      eff_d = min7(code_q, PRECHG_CODE);
    end else if (SINGLE_CELL && BAT_BELOW_MINIMUM_SYSTEM_VOLTAGE) begin
      eff_d = min7(code_q, MID_CODE);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      EFF_CHARGE_CODE <= CC_CODE_RST;
      CHARGE_ENABLE   <= 1'b0;
    end else begin
      EFF_CHARGE_CODE <= eff_d;
      CHARGE_ENABLE   <= (code_q != 7'h00);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped commands read zero; reserved bits read zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      RD_DATA  <= 16'h0000;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_STB;
      if (RD_STB) begin
        RD_DATA <= 16'h0000;
        if (RD_WORD && RD_CMD == CMD_CC_WORD)
          RD_DATA <= {3'h0, code_q, 6'h00};
        else if (RD_WORD && RD_CMD == CMD_OPT_WORD)
          RD_DATA <= {thr_q, dg_q, 1'b0, env_q};
        else if (!RD_WORD && RD_CMD == CMD_CC_LO)
          RD_DATA <= {8'h00, code_q[1:0], 6'h00};
        else if (!RD_WORD && RD_CMD == CMD_CC_HI)
          RD_DATA <= {11'h000, code_q[6:2]};
        else if (!RD_WORD && RD_CMD == CMD_OPT_LO)
          RD_DATA <= {9'h000, env_q};
        else if (!RD_WORD && RD_CMD == CMD_OPT_HI)
          RD_DATA <= {8'h00, thr_q, dg_q};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_bad_word_kept: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (cc_word && word_bad) |=> (code_q == $past(code_q)) && INVALID_WR)
    else $error("invalid word changed charge code");

  a_reset_zero: assert property (
    @(posedge CORE_CLK) !RESET_N |=> (code_q == 7'h00) && !CHARGE_ENABLE)
    else $error("charge code not zero after reset");

  a_zero_stops: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (cc_word && !word_bad && WR_DATA[12:6] == 7'h00) |=> ##1 !CHARGE_ENABLE)
    else $error("charging not stopped by zero write");

  a_prechg_clamp: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    PRE_CHARGE |=> (EFF_CHARGE_CODE <= 7'd6))
    else $error("pre-charge current above 384 mA");

  a_mid_clamp: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (SINGLE_CELL && !PRE_CHARGE && !BAT_BELOW_LOW && BAT_BELOW_MINIMUM_SYSTEM_VOLTAGE)
    |=> (EFF_CHARGE_CODE == min7($past(code_q), 7'd31)))
    else $error("single cell middle clamp wrong");

  a_high_first: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (cc_hi && !pend_q) |=> $stable(code_q))
    else $error("lone high byte changed charge code");

  a_pair_apply: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (cc_hi && pend_q && !(|WR_DATA[7:5]))
    |=> (code_q == {$past(WR_DATA[4:0]), $past(lo_q[7:6])}))
    else $error("byte pair not applied");

  a_wdog_drop: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (pend_q && wd_done && !WR_STB) |=> !pend_q)
    else $error("stale low byte kept");

  a_adapter_mask: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !ADAPTER_PRESENT |-> (eff_en[5:4] == 2'b00) && (eff_en[1:0] == 2'b00)
    && (eff_en[6] == env_q[6]) && (eff_en[3:2] == env_q[3:2]))
    else $error("adapter removal mask wrong");

  a_quiet_disabled: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (eff_en == 7'h00 && hold_q == '0 && !ext_q) |=> PROC_HOT_N)
    else $error("alert driven with no source enabled");

  a_width_load: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (alert && !alert_q) |=> !PROC_HOT_N &&
    (hold_q == sel4($past(PULSE_WIDTH_SEL), DG_100US, PW_1MS, DG_12MS,
                    DG_6MS) - 1'b1))
    else $error("alert minimum width not loaded");

  a_dchg_trip: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (DISCHARGE_MA <= {1'b0, thr_q, 9'h000}) |=> !dchg_filt)
    else $error("discharge trip below threshold");

endmodule

// >>> logic/hot_charge_pkg.sv
package hot_charge_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int CLK_MHZ = 200;

  // Deglitch and pulse times in microseconds
  localparam int T_1P6MS_US = 1600;
  localparam int T_100US_US = 100;
  localparam int T_6MS_US   = 6000;
  localparam int T_12MS_US  = 12000;
  localparam int T_1MS_US   = 1000;

  // Cycle counts, whole microseconds times an integral rate, so exact
  localparam int T_1P6MS_CYC = T_1P6MS_US * CLK_MHZ;
  localparam int T_100US_CYC = T_100US_US * CLK_MHZ;
  localparam int T_6MS_CYC   = T_6MS_US * CLK_MHZ;
  localparam int T_12MS_CYC  = T_12MS_US * CLK_MHZ;
  localparam int T_1MS_CYC   = T_1MS_US * CLK_MHZ;

  // Pending low byte lifetime, no figure known so a plain default
  localparam int WDOG_CYC_DEF = 1000000;

  localparam int CNT_W = 22;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_CC_WORD  = 8'h14;
  localparam logic [7:0] CMD_OPT_WORD = 8'h3D;
  localparam logic [7:0] CMD_CC_LO    = 8'h0A;
  localparam logic [7:0] CMD_CC_HI    = 8'h0B;
  localparam logic [7:0] CMD_OPT_LO   = 8'h06;
  localparam logic [7:0] CMD_OPT_HI   = 8'h07;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int CC_CODE_LSB = 6;
  localparam int CC_CODE_MSB = 12;
  localparam int CC_BAD_LSB  = 13;
  localparam int CC_BAD_MSB  = 15;
  localparam int OPT_THR_LSB = 10;
  localparam int OPT_THR_MSB = 15;
  localparam int OPT_DG_LSB  = 8;
  localparam int OPT_DG_MSB  = 9;
  localparam int OPT_ENV_MSB = 6;
  localparam int THR_STEP_SH = 9;

  localparam logic [6:0] CC_CODE_RST = 7'h00;
  localparam logic [5:0] THR_RST     = 6'h20;
  localparam logic [1:0] DG_RST      = 2'h1;
  localparam logic [6:0] ENV_RST     = 7'h24;
  // Sources kept while the adapter is absent: comparator, discharge, sys
  localparam logic [6:0] ENV_KEEP    = 7'h4C;
  localparam logic [6:0] ENV_ALL     = 7'h7F;

  // ****************************************
  // Charge current clamps
  // ****************************************
  localparam int CC_STEP_MA   = 64;
  localparam int PRECHG_MA    = 384;
  localparam int MID_CLAMP_MA = 2000;
  localparam logic [6:0] PRECHG_CODE = 7'(PRECHG_MA / CC_STEP_MA);
  localparam logic [6:0] MID_CODE    = 7'(MID_CLAMP_MA / CC_STEP_MA);

endpackage

// >>> logic/deglitch_filter.sv
`timescale 1ns/100ps
module deglitch_filter (
  // Clock and reset
  input  wire logic                           CORE_CLK,
  input  wire logic                           RESET_N,
  // Raw level and qualifying length
  input  wire logic                           RAW,
  input  wire logic [hot_charge_pkg::CNT_W-1:0] LIMIT,
  // Filtered level
  output logic                                FILT
);
  import hot_charge_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  // ****************************************
  // Qualify a level held for LIMIT cycles
  // ****************************************
  // Drop is immediate so a release never lingers past the trip
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      cnt_q <= '0;
      FILT  <= 1'b0;
    end else if (!RAW) begin
      cnt_q <= '0;
      FILT  <= 1'b0;
    end else if (cnt_q + 1'b1 >= LIMIT) begin
      FILT <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// >>> testbench/host_model.sv
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic        CORE_CLK,
  // Command port toward the block
  output logic             WR_STB,
  output logic             WR_WORD,
  output logic [7:0]       WR_CMD,
  output logic [15:0]      WR_DATA,
  output logic             RD_STB,
  output logic             RD_WORD,
  output logic [7:0]       RD_CMD,
  // Answers from the block
  input  wire logic [15:0] RD_DATA,
  input  wire logic        RD_VALID,
  input  wire logic        INVALID_WR
);
  import hot_charge_pkg::*;

  // Idle port at time zero
  initial begin
    WR_STB  = 1'b0;
    WR_WORD = 1'b0;
    WR_CMD  = 8'h00;
    WR_DATA = 16'h0000;
    RD_STB  = 1'b0;
    RD_WORD = 1'b0;
    RD_CMD  = 8'h00;
  end

  // One command per strobe; data flips after release so stale data shows
  task automatic wr(input logic w, input logic [7:0] c,
                    input logic [15:0] d, output logic inv);
    @(posedge CORE_CLK);
    WR_STB  <= 1'b1;
    WR_WORD <= w;
    WR_CMD  <= c;
    WR_DATA <= d;
    @(posedge CORE_CLK);
    WR_STB  <= 1'b0;
    WR_DATA <= ~d;
    #1 inv = INVALID_WR;
  endtask

  // Read answer only counts while the valid pulse stands
  task automatic rd(input logic w, input logic [7:0] c,
                    output logic [15:0] d);
    @(posedge CORE_CLK);
    RD_STB  <= 1'b1;
    RD_WORD <= w;
    RD_CMD  <= c;
    @(posedge CORE_CLK);
    RD_STB  <= 1'b0;
    RD_CMD  <= ~c;
    #1 d = (RD_VALID === 1'b1) ? RD_DATA : 16'hXXXX;
  endtask

  // Charge current byte pair; host sends the low byte before the high
  task automatic wr_pair(input logic [7:0] lo, input logic [7:0] hi);
    logic inv;
    wr(1'b0, CMD_CC_LO, {8'h00, lo}, inv);
    wr(1'b0, CMD_CC_HI, {8'h00, hi}, inv);
  endtask
endmodule

// >>> testbench/tb_hot_charge_regs.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  n_fail++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_hot_charge_regs;
  import hot_charge_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        wr_stb, wr_word, rd_stb, rd_word, rd_valid, inv_wr;
  logic [7:0]  wr_cmd, rd_cmd;
  logic [15:0] wr_data, rd_data;
  logic [15:0] dchg     = 16'h0000;
  logic [5:0]  src      = 6'h00;
  logic        adp      = 1'b1;
  logic [3:0]  chg      = 4'h0;
  logic [1:0]  pw_sel   = 2'h1;
  logic        ext      = 1'b0;
  logic        clr      = 1'b0;
  logic        proc_hot_n, charge_en;
  logic [6:0]  eff;
  int          n_fail   = 0;
  int          n_tests  = 0;
  int          cyc      = 0;

  // ****************************************
  // Block and host
  // ****************************************
  hot_charge_regs #(.DG_1P6MS(20), .DG_100US(5), .DG_6MS(30),
    .DG_12MS(40), .PW_1MS(10), .WDOG_CYC(50)) i_dut (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .WR_STB(wr_stb),
    .WR_WORD(wr_word), .WR_CMD(wr_cmd), .WR_DATA(wr_data),
    .RD_STB(rd_stb), .RD_WORD(rd_word), .RD_CMD(rd_cmd),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .INVALID_WR(inv_wr),
    .DISCHARGE_MA(dchg), .IND_COMP_TRIP(src[5]),
    .CRIT_INPUT_TRIP(src[4]), .NOM_INPUT_TRIP(src[3]),
    .SYS_VOLT_TRIP(src[2]), .BATTERY_PRESENT(src[1]),
    .ADAPTER_GOOD(~src[0]), .ADAPTER_PRESENT(adp),
    .PULSE_WIDTH_SEL(pw_sel), .PULSE_EXTEND(ext), .HOST_CLEAR(clr),
    .PROC_HOT_N(proc_hot_n), .PRE_CHARGE(chg[3]),
    .SINGLE_CELL(chg[2]), .BAT_BELOW_LOW(chg[1]),
    .BAT_BELOW_MINIMUM_SYSTEM_VOLTAGE(chg[0]), .EFF_CHARGE_CODE(eff),
    .CHARGE_ENABLE(charge_en));

  host_model host (.CORE_CLK(core_clk), .WR_STB(wr_stb),
    .WR_WORD(wr_word), .WR_CMD(wr_cmd), .WR_DATA(wr_data),
    .RD_STB(rd_stb), .RD_WORD(rd_word), .RD_CMD(rd_cmd),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .INVALID_WR(inv_wr));

  // Clock and hang guard, sized well above the whole run
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] d;
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h0000)
    host.rd(1'b1, CMD_OPT_WORD, d);
    `CHK(d, 16'h8124)
    `CHK(charge_en, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_word();
    logic [15:0] d;
    logic        inv;
    host.wr(1'b1, CMD_CC_WORD, 16'h1FFF, inv);
    `CHK(inv, 1'b0)
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h1FC0)
    `CHK(eff, 7'h7F)
    host.wr(1'b1, CMD_CC_WORD, 16'hE040, inv);
    `CHK(inv, 1'b1)
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h1FC0)
    // no battery, so the host writes zero
    host.wr(1'b1, CMD_CC_WORD, 16'h0000, inv);
    repeat (2) @(posedge core_clk);
    #1 `CHK(charge_en, 1'b0)
    $display("test word done");
  endtask

  task automatic t_pair();
    logic [15:0] d;
    logic        inv;
    host.wr_pair(8'hC0, 8'h05);
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h05C0)
    host.wr(1'b0, CMD_CC_HI, 16'h001F, inv);
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h05C0)
    // Pair whose high byte sets an unused bit is refused
    host.wr(1'b0, CMD_CC_LO, 16'h0040, inv);
    host.wr(1'b0, CMD_CC_HI, 16'h0021, inv);
    `CHK(inv, 1'b1)
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h05C0)
    host.wr(1'b0, CMD_CC_LO, 16'h0040, inv);
    repeat (60) @(posedge core_clk);
    host.wr(1'b0, CMD_CC_HI, 16'h0001, inv);
    host.rd(1'b1, CMD_CC_WORD, d);
    `CHK(d, 16'h05C0)
    $display("test pair done");
  endtask

  task automatic t_clamp();
    logic [3:0] m [4] = '{4'h8, 4'h6, 4'h5, 4'h4};
    logic [6:0] e [4] = '{7'h06, 7'h06, 7'h1F, 7'h40};
    logic       inv;
    host.wr(1'b1, CMD_CC_WORD, 16'h1000, inv);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      chg <= m[i];
      repeat (3) @(posedge core_clk);
      #1 `CHK(eff, e[i])
    end
    `CHK(charge_en, 1'b1)
    $display("test clamp done");
  endtask

  // Alert from one envelope setting and one-cycle source pulse
  task automatic hot(input logic [6:0] env, input logic [5:0] t,
                     input logic exp);
    logic inv;
    host.wr(1'b0, CMD_OPT_LO, {9'h000, env}, inv);
    @(posedge core_clk);
    src <= t;
    @(posedge core_clk);
    src <= 6'h00;
    #1 `CHK(proc_hot_n, exp)
    repeat (5) @(posedge core_clk);
    #1 `CHK(proc_hot_n, exp)
    repeat (15) @(posedge core_clk);
    #1 `CHK(proc_hot_n, 1'b1)
  endtask

  task automatic t_alert();
    hot(7'h40, 6'h20, 1'b0);
    hot(7'h20, 6'h10, 1'b0);
    hot(7'h10, 6'h08, 1'b0);
    hot(7'h04, 6'h04, 1'b0);
    hot(7'h02, 6'h02, 1'b0);
    hot(7'h01, 6'h01, 1'b0);
    hot(7'h00, 6'h3F, 1'b1);
    hot(7'h5B, 6'h14, 1'b1);
    adp <= 1'b0;
    hot(7'h33, 6'h1B, 1'b1);
    hot(7'h04, 6'h04, 1'b0);
    adp <= 1'b1;
    $display("test alert done");
  endtask

  // Trip just above one threshold step, each deglitch code in turn
  task automatic t_dchg();
    int   lim [4] = '{20, 5, 30, 40};
    int   n;
    logic inv;
    for (int g = 0; g < 4; g++) begin
      host.wr(1'b1, CMD_OPT_WORD, {6'h01, 2'(g), 8'h08}, inv);
      @(posedge core_clk);
      dchg <= 16'd513;
      n = 0;
      while (proc_hot_n !== 1'b0 && n < 100) begin
        @(posedge core_clk);
        #1 n++;
      end
      `CHK(n >= lim[g] && n <= lim[g] + 4, 1'b1)
      @(posedge core_clk);
      dchg <= 16'd512;
      repeat (60) @(posedge core_clk);
      #1 `CHK(proc_hot_n, 1'b1)
    end
    $display("test discharge done");
  endtask

  // Shortest width, then a held alert released by the host clear
  task automatic t_ext();
    logic inv;
    host.wr(1'b0, CMD_OPT_LO, 16'h0004, inv);
    @(posedge core_clk);
    pw_sel <= 2'h0;
    src    <= 6'h04;
    @(posedge core_clk);
    src <= 6'h00;
    #1 `CHK(proc_hot_n, 1'b0)
    repeat (3) @(posedge core_clk);
    #1 `CHK(proc_hot_n, 1'b0)
    repeat (3) @(posedge core_clk);
    #1 `CHK(proc_hot_n, 1'b1)
    @(posedge core_clk);
    ext <= 1'b1;
    src <= 6'h04;
    @(posedge core_clk);
    src <= 6'h00;
    repeat (30) @(posedge core_clk);
    #1 `CHK(proc_hot_n, 1'b0)
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr    <= 1'b0;
    ext    <= 1'b0;
    pw_sel <= 2'h1;
    @(posedge core_clk);
    #1 `CHK(proc_hot_n, 1'b1)
    $display("test extend done");
  endtask

  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_word();
    t_pair();
    t_clamp();
    t_alert();
    t_dchg();
    t_ext();
    stop_test();
  end
endmodule
